// file: design/flash_power_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the power-up and busy timing block.
// ----------------------------------------------------------------------------
package flash_power_pkg;

    // ------------------------------------------------------------------------
    // Clock and counter geometry.
    // ------------------------------------------------------------------------
    // Period of the system clock in nanoseconds (200 MHz).
    localparam real CLK_PERIOD_NS = 5.0;
    // Width of every duration counter; the longest count needs 30 bits.
    localparam int  COUNT_W       = 32;

    // ------------------------------------------------------------------------
    // Times in their own units, as printed.
    // ------------------------------------------------------------------------
    // Least wait from power good to the first read frame.
    localparam int  READ_AFTER_POWER_WAIT_US         = 70;
    // Longest internal delay before program or erase is allowed.
    localparam int  WRITE_AFTER_POWER_WAIT_MS        = 3;
    // Longest full page program time.
    localparam real PAGE_WRITE_DURATION_MS           = 2.5;
    // Longest page erase time.
    localparam int  PAGE_CLEAR_DURATION_MS           = 20;
    // Longest block erase times for 4K, 32K and 64K blocks.
    localparam int  BLOCK4K_CLEAR_DURATION_MS        = 60;
    localparam int  BLOCK32K_CLEAR_DURATION_MS       = 500;
    localparam int  BLOCK64K_CLEAR_DURATION_MS       = 1000;
    // Longest whole array erase time.
    localparam real WHOLE_ARRAY_CLEAR_DURATION_S     = 4.0;
    // Longest security area program time.
    localparam int  SECURITY_AREA_WRITE_DURATION_US  = 950;
    // Longest status register write time.
    localparam int  STATUS_WRITE_DURATION_NS         = 200;

    // ------------------------------------------------------------------------
    // Conversions from nanoseconds to clock cycles.
    // ------------------------------------------------------------------------
    // A longest time rounds down, never below one cycle.
    function automatic int unsigned cycles_floor(input real ns);
        int unsigned c;
        c = $rtoi(ns / CLK_PERIOD_NS);
        return (c < 1) ? 1 : c;
    endfunction

    // A least time rounds up, never below one cycle.
    function automatic int unsigned cycles_ceil(input real ns);
        int unsigned c;
        c = $rtoi(ns / CLK_PERIOD_NS);
        if (real'(c) * CLK_PERIOD_NS < ns) c = c + 1;
        return (c < 1) ? 1 : c;
    endfunction

    // ------------------------------------------------------------------------
    // Cycle counts derived from the times above.
    // ------------------------------------------------------------------------
    localparam int unsigned READ_WAIT_CYCLES      =
        cycles_ceil(READ_AFTER_POWER_WAIT_US * 1.0E3);
    localparam int unsigned WRITE_WAIT_CYCLES     =
        cycles_floor(WRITE_AFTER_POWER_WAIT_MS * 1.0E6);
    localparam int unsigned PAGE_WRITE_CYCLES     =
        cycles_floor(PAGE_WRITE_DURATION_MS * 1.0E6);
    localparam int unsigned PAGE_CLEAR_CYCLES     =
        cycles_floor(PAGE_CLEAR_DURATION_MS * 1.0E6);
    localparam int unsigned BLOCK4K_CLEAR_CYCLES  =
        cycles_floor(BLOCK4K_CLEAR_DURATION_MS * 1.0E6);
    localparam int unsigned BLOCK32K_CLEAR_CYCLES =
        cycles_floor(BLOCK32K_CLEAR_DURATION_MS * 1.0E6);
    localparam int unsigned BLOCK64K_CLEAR_CYCLES =
        cycles_floor(BLOCK64K_CLEAR_DURATION_MS * 1.0E6);
    localparam int unsigned WHOLE_CLEAR_CYCLES    =
        cycles_floor(WHOLE_ARRAY_CLEAR_DURATION_S * 1.0E9);
    localparam int unsigned SECURITY_WRITE_CYCLES =
        cycles_floor(SECURITY_AREA_WRITE_DURATION_US * 1.0E3);
    localparam int unsigned STATUS_WRITE_CYCLES   =
        cycles_floor(STATUS_WRITE_DURATION_NS * 1.0);

    // ------------------------------------------------------------------------
    // Enumerations.
    // ------------------------------------------------------------------------
    // Kind of long operation requested by the command decoder.
    typedef enum logic [2:0] {
        OP_PAGE_WRITE,
        OP_PAGE_CLEAR,
        OP_BLOCK4K_CLEAR,
        OP_BLOCK32K_CLEAR,
        OP_BLOCK64K_CLEAR,
        OP_WHOLE_CLEAR,
        OP_SECURITY_WRITE,
        OP_STATUS_WRITE
    } op_kind_t;

    // Power state of the device.
    typedef enum logic [1:0] {
        ST_POWER_WAIT,
        ST_STANDBY,
        ST_ACTIVE
    } power_state_t;

endpackage

// file: design/countdown_timer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Loadable down counter that runs for exactly the loaded number of cycles.
// ----------------------------------------------------------------------------
module countdown_timer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              running,
    output logic              done
);
    // Cycles still to run.
    logic [W-1:0] count_q;
    // Next count and the last-cycle marker.
    logic [W-1:0] count_d;
    wire          last_cycle = running && (count_q == W'(1));

    // A load restarts the count; zero is treated as one cycle.
    assign count_d = load ? ((value == '0) ? W'(1) : value)
                   : (running ? count_q - W'(1) : count_q);

    // Count, run flag and one-cycle finish pulse.
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            count_q <= count_d;
            running <= load || (running && !last_cycle);
            done    <= last_cycle && !load;
        end
    end
endmodule // countdown_timer

// file: design/select_edge_sampler.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Watches the select line, marks each falling edge and samples the idle clock.
// ----------------------------------------------------------------------------
module select_edge_sampler (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic select_n,
    input  wire logic sck,
    output logic      select_fall,
    output logic      mode3
);
    // Select level seen on the previous edge; reset low so that a line
    // already low at release does not count as a falling edge.
    logic select_n_q;
    wire  fall_now = select_n_q && !select_n;

    // Edge pulse and clock-level capture at every falling edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            select_n_q  <= 1'b0;
            select_fall <= 1'b0;
            mode3       <= 1'b0;
        end else begin
            select_n_q  <= select_n;
            select_fall <= fall_now;
            if (fall_now) begin
                mode3 <= sck;
            end
        end
    end
endmodule // select_edge_sampler

// file: design/flash_powerup_busy.sv
`timescale 1ns/10ps
// How it works
// - Output stays undriven until output requested.
// - First instruction needs a select falling edge.
// - Each select fall samples clock: mode.
// - In reset, all commands are ignored.
// - Program/erase blocked for 3 ms after power.
// - Delay end: standby or active by select.
// - Page program busy at most 2.5 ms.
// - Erase busy within page/block/chip limits.
// - Security area program within 950 us.
// - Status write done within 200 ns.
module flash_powerup_busy #(
    parameter int unsigned READ_WAIT      = flash_power_pkg::READ_WAIT_CYCLES,
    parameter int unsigned WRITE_WAIT     = flash_power_pkg::WRITE_WAIT_CYCLES,
    parameter int unsigned PAGE_WRITE     = flash_power_pkg::PAGE_WRITE_CYCLES,
    parameter int unsigned PAGE_CLEAR     = flash_power_pkg::PAGE_CLEAR_CYCLES,
    parameter int unsigned BLOCK4K_CLEAR  = flash_power_pkg::BLOCK4K_CLEAR_CYCLES,
    parameter int unsigned BLOCK32K_CLEAR = flash_power_pkg::BLOCK32K_CLEAR_CYCLES,
    parameter int unsigned BLOCK64K_CLEAR = flash_power_pkg::BLOCK64K_CLEAR_CYCLES,
    parameter int unsigned WHOLE_CLEAR    = flash_power_pkg::WHOLE_CLEAR_CYCLES,
    parameter int unsigned SECURITY_WRITE = flash_power_pkg::SECURITY_WRITE_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      select_n,
    input  wire logic                      sck,
    input  wire logic                      op_start,
    input  wire flash_power_pkg::op_kind_t op_kind,
    input  wire logic                      out_request,
    output logic                           so_oe_q,
    output logic                           frame_open_q,
    output logic                           mode3_q,
    output logic                           busy_q,
    output logic                           op_done_q,
    output logic                           op_refused_q,
    output logic                           read_ready_q,
    output logic                           write_ready_q,
    output logic                           standby_q,
    output logic                           active_q
);
    // ------------------------------------------------------------------------
    // Local declarations.
    // ------------------------------------------------------------------------
    localparam int CW = flash_power_pkg::COUNT_W;

    // Power state and its next value.
    flash_power_pkg::power_state_t state_q;
    flash_power_pkg::power_state_t state_d;
    // High for the first cycle after reset release, to start the write delay.
    logic          started_q;
    // Counter for the read wait after power good.
    logic [CW-1:0] read_count_q;
    logic [CW-1:0] read_count_d;
    // Outputs of the edge sampler.
    logic          select_fall;
    logic          mode3;
    // Power-up write delay timer.
    logic          pu_done;
    // Operation timer.
    logic          op_running;
    logic          op_done;
    // Next values of the registered outputs.
    logic          frame_open_d;
    logic          so_oe_d;
    logic          busy_d;

    // ------------------------------------------------------------------------
    // Duration of each operation kind, in cycles.
    // ------------------------------------------------------------------------
    function automatic logic [CW-1:0] op_cycles(input flash_power_pkg::op_kind_t k);
        case (k)
            flash_power_pkg::OP_PAGE_WRITE:     return CW'(PAGE_WRITE);
            flash_power_pkg::OP_PAGE_CLEAR:     return CW'(PAGE_CLEAR);
            flash_power_pkg::OP_BLOCK4K_CLEAR:  return CW'(BLOCK4K_CLEAR);
            flash_power_pkg::OP_BLOCK32K_CLEAR: return CW'(BLOCK32K_CLEAR);
            flash_power_pkg::OP_BLOCK64K_CLEAR: return CW'(BLOCK64K_CLEAR);
            flash_power_pkg::OP_WHOLE_CLEAR:    return CW'(WHOLE_CLEAR);
            flash_power_pkg::OP_SECURITY_WRITE: return CW'(SECURITY_WRITE);
            flash_power_pkg::OP_STATUS_WRITE:
                return CW'(flash_power_pkg::STATUS_WRITE_CYCLES);
            default:                            return CW'(1);
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // Select edge detection and mode capture.
    // ------------------------------------------------------------------------
    select_edge_sampler u_sampler (
        .clk         (clk),
        .rst         (rst),
        .select_n    (select_n),
        .sck         (sck),
        .select_fall (select_fall),
        .mode3       (mode3)
    );

    // ------------------------------------------------------------------------
    // Power-up write delay, started on the first cycle after reset.
    // ------------------------------------------------------------------------
    countdown_timer #(
        .W (CW)
    ) u_powerup_timer (
        .clk     (clk),
        .rst     (rst),
        .load    (started_q),
        .value   (CW'(WRITE_WAIT)),
        .running (),
        .done    (pu_done)
    );

    // ------------------------------------------------------------------------
    // Acceptance of a long operation.
    // ------------------------------------------------------------------------
    // The status write is a register write and needs no array power-up;
    // every program or erase waits for the power-up delay.
    wire is_array_op   = (op_kind != flash_power_pkg::OP_STATUS_WRITE);
    wire kind_allowed  = !is_array_op || write_ready_q;
    // A request counts only inside an accepted frame.
    wire op_seen       = op_start && frame_open_q;
    // Accepted when idle and allowed; otherwise refused with a pulse.
    wire op_accept     = op_seen && !busy_q && kind_allowed;
    wire op_reject     = op_seen && !op_accept;

    countdown_timer #(
        .W (CW)
    ) u_op_timer (
        .clk     (clk),
        .rst     (rst),
        .load    (op_accept),
        // One less: the registered busy flag adds the load cycle itself.
        .value   (op_cycles(op_kind) - CW'(1)),
        .running (op_running),
        .done    (op_done)
    );

    // ------------------------------------------------------------------------
    // Next-value decoding.
    // ------------------------------------------------------------------------
    // A frame opens only on a falling edge of select and closes when select
    // rises; a line held low through reset release opens nothing.
    assign frame_open_d = select_fall ? 1'b1
                        : (select_n ? 1'b0 : frame_open_q);
    // The output driver turns on only while an open frame asks for data.
    assign so_oe_d      = frame_open_d && out_request;
    // Busy rises with the accepted request and falls with the timer.
    assign busy_d       = op_accept || (op_running && !op_done);
    // Read wait counter stops at the limit.
    assign read_count_d = (read_count_q == CW'(READ_WAIT)) ? read_count_q
                        : read_count_q + CW'(1);

    // ------------------------------------------------------------------------
    // Power state decoding.
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            // Waiting out the delay before program or erase.
            flash_power_pkg::ST_POWER_WAIT: begin
                if (pu_done) begin
                    state_d = select_n ? flash_power_pkg::ST_STANDBY
                                       : flash_power_pkg::ST_ACTIVE;
                end
            end
            // Standby follows select; an operation keeps the device active.
            flash_power_pkg::ST_STANDBY: begin
                if (!select_n || busy_q) begin
                    state_d = flash_power_pkg::ST_ACTIVE;
                end
            end
            // Back to standby once select is high and nothing is running.
            flash_power_pkg::ST_ACTIVE: begin
                if (select_n && !busy_q) begin
                    state_d = flash_power_pkg::ST_STANDBY;
                end
            end
            default: begin
                state_d = flash_power_pkg::ST_POWER_WAIT;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Power-up bookkeeping; reset holds everything still and drops requests.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            started_q     <= 1'b1;
            state_q       <= flash_power_pkg::ST_POWER_WAIT;
            read_count_q  <= '0;
            read_ready_q  <= 1'b0;
            write_ready_q <= 1'b0;
        end else begin
            started_q     <= 1'b0;
            state_q       <= state_d;
            read_count_q  <= read_count_d;
            read_ready_q  <= (read_count_d == CW'(READ_WAIT));
            write_ready_q <= write_ready_q || pu_done;
        end
    end

    // ------------------------------------------------------------------------
    // Frame, output enable and mode outputs.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_open_q <= 1'b0;
            so_oe_q      <= 1'b0;
            mode3_q      <= 1'b0;
        end else begin
            frame_open_q <= frame_open_d;
            so_oe_q      <= so_oe_d;
            mode3_q      <= mode3;
        end
    end

    // ------------------------------------------------------------------------
    // Busy flag and operation event pulses.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q       <= 1'b0;
            op_done_q    <= 1'b0;
            op_refused_q <= 1'b0;
        end else begin
            busy_q       <= busy_d;
            op_done_q    <= op_done;
            op_refused_q <= op_reject;
        end
    end

    // ------------------------------------------------------------------------
    // Standby and active indications, decoded from the next state.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            standby_q <= 1'b0;
            active_q  <= 1'b0;
        end else begin
            standby_q <= (state_d == flash_power_pkg::ST_STANDBY);
            active_q  <= (state_d == flash_power_pkg::ST_ACTIVE);
        end
    end

endmodule // flash_powerup_busy

// file: testbench/flash_powerup_busy_chk.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port-level checker for the power-up and busy timing block.
// ----------------------------------------------------------------------------
module flash_powerup_busy_chk #(
    parameter int unsigned PAGE_WRITE     = 20,
    parameter int unsigned PAGE_CLEAR     = 20,
    parameter int unsigned BLOCK4K_CLEAR  = 20,
    parameter int unsigned BLOCK32K_CLEAR = 20,
    parameter int unsigned BLOCK64K_CLEAR = 20,
    parameter int unsigned WHOLE_CLEAR    = 20,
    parameter int unsigned SECURITY_WRITE = 20
) (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      select_n,
    input wire logic                      sck,
    input wire logic                      op_start,
    input wire flash_power_pkg::op_kind_t op_kind,
    input wire logic                      so_oe_q,
    input wire logic                      frame_open_q,
    input wire logic                      mode3_q,
    input wire logic                      busy_q,
    input wire logic                      op_done_q,
    input wire logic                      op_refused_q,
    input wire logic                      write_ready_q,
    input wire logic                      standby_q,
    input wire logic                      active_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Busy cycles so far and the length owed by the operation taken.
    localparam int unsigned OWED [8] = '{PAGE_WRITE, PAGE_CLEAR, BLOCK4K_CLEAR,
        BLOCK32K_CLEAR, BLOCK64K_CLEAR, WHOLE_CLEAR, SECURITY_WRITE,
        flash_power_pkg::STATUS_WRITE_CYCLES};
    logic [31:0] cnt_q, dur_q;
    logic        taken; // A request that the block must accept.
    assign taken = op_start && frame_open_q && !busy_q
        && (op_kind == flash_power_pkg::OP_STATUS_WRITE || write_ready_q);
    // Reset clears both so that a new run starts clean.
    always_ff @(posedge clk) begin
        cnt_q <= (rst || !busy_q) ? 32'h0 : cnt_q + 32'h1;
        dur_q <= rst ? 32'h0 : (taken ? 32'(OWED[op_kind]) : dur_q);
    end
    // A status write accepted in an open frame.
    sequence status_taken_s;
        taken && op_kind == flash_power_pkg::OP_STATUS_WRITE;
    endsequence
    // Busy running out at its natural end.
    sequence busy_end_s;
        op_done_q && !busy_q;
    endsequence

    chk_oe_in_frame: assert property (so_oe_q |-> frame_open_q)
        else $error("oe outside frame");
    chk_frame_after_fall: assert property ($rose(frame_open_q) |->
        $past(select_n, 3) && !$past(select_n, 2)) else $error("frame w/o fall");
    chk_mode_sample: assert property ($rose(frame_open_q) |->
        mode3_q == $past(sck, 2)) else $error("bad mode");
    chk_reset_quiet: assert property ($past(rst) |-> !(so_oe_q || frame_open_q || busy_q
        || op_done_q || op_refused_q || write_ready_q || standby_q || active_q))
        else $error("not quiet after reset");
    chk_array_after_delay: assert property ($rose(busy_q)
        && $past(op_kind) != flash_power_pkg::OP_STATUS_WRITE |-> $past(write_ready_q))
        else $error("array op too early");
    chk_refuse_early: assert property (op_start && frame_open_q && !busy_q && !write_ready_q
        && op_kind != flash_power_pkg::OP_STATUS_WRITE |=> op_refused_q && !busy_q)
        else $error("early op not refused");
    chk_one_state: assert property ($rose(write_ready_q) |-> ##[0:2] (standby_q != active_q))
        else $error("no single state");
    chk_status_time: assert property (status_taken_s |=> busy_q ##40 busy_end_s)
        else $error("status length");
    chk_busy_length: assert property (op_done_q |-> cnt_q == dur_q)
        else $error("busy length");
    chk_done_with_fall: assert property ($fell(busy_q) && !$past(rst) |-> op_done_q)
        else $error("busy fell w/o done");
    chk_busy_refuse: assert property (busy_q && op_start && frame_open_q |=> op_refused_q)
        else $error("busy op not refused");
endmodule // flash_powerup_busy_chk

bind flash_powerup_busy flash_powerup_busy_chk #(.PAGE_WRITE(PAGE_WRITE),
    .PAGE_CLEAR(PAGE_CLEAR), .BLOCK4K_CLEAR(BLOCK4K_CLEAR), .BLOCK32K_CLEAR(BLOCK32K_CLEAR),
    .BLOCK64K_CLEAR(BLOCK64K_CLEAR), .WHOLE_CLEAR(WHOLE_CLEAR),
    .SECURITY_WRITE(SECURITY_WRITE)) chk_inst (.clk, .rst, .select_n, .sck, .op_start,
    .op_kind, .so_oe_q, .frame_open_q, .mode3_q, .busy_q, .op_done_q, .op_refused_q,
    .write_ready_q, .standby_q, .active_q);

// file: testbench/spi_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Host that frames instructions with select and an idle-parked serial clock.
// ----------------------------------------------------------------------------
module spi_host_model (
    input  wire logic clk,
    input  wire logic frame_req, // Level asking for an open frame.
    input  wire logic idle_high, // Idle clock level: high selects mode 3.
    output logic      select_n,
    output logic      sck
);
    initial begin
        select_n = 1'b1;
        sck      = 1'b0;
    end
    // The clock stands at its idle level outside frames and runs inside them.
    always @(posedge clk) begin
        if (!frame_req) begin
            select_n <= 1'b1;
            sck      <= idle_high;
        end else if (select_n) begin
            select_n <= 1'b0;
        end else begin
            sck <= ~sck;
        end
    end
endmodule // spi_host_model

// file: testbench/flash_powerup_busy_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench with shortened power-up and operation counts.
// ----------------------------------------------------------------------------
module flash_powerup_busy_tb_top;
    localparam int unsigned RW = 30;             // Shortened read wait.
    localparam int unsigned WW = 60;             // Shortened write wait.
    localparam int unsigned DUR [7] = '{20, 24, 28, 32, 36, 40, 44};
    localparam int unsigned STATUS_N = 200 / 5;  // Status write length in cycles.
    logic clk = 1'b0, rst = 1'b1, op_start = 1'b0, out_request = 1'b0;
    logic frame_req = 1'b1, idle_high = 1'b0, select_n, sck;
    logic so_oe_q, frame_open_q, mode3_q, busy_q, op_done_q, op_refused_q;
    logic read_ready_q, write_ready_q, standby_q, active_q;
    flash_power_pkg::op_kind_t op_kind = flash_power_pkg::OP_STATUS_WRITE;
    int num_errors = 0, total_checks = 0;

    always #2.5 clk = ~clk;
    spi_host_model spi_host_model_inst (.clk, .frame_req, .idle_high, .select_n, .sck);
    flash_powerup_busy #(.READ_WAIT(RW), .WRITE_WAIT(WW), .PAGE_WRITE(DUR[0]),
        .PAGE_CLEAR(DUR[1]), .BLOCK4K_CLEAR(DUR[2]), .BLOCK32K_CLEAR(DUR[3]),
        .BLOCK64K_CLEAR(DUR[4]), .WHOLE_CLEAR(DUR[5]), .SECURITY_WRITE(DUR[6]))
        flash_powerup_busy_inst (.clk, .rst, .select_n, .sck, .op_start, .op_kind,
        .out_request, .so_oe_q, .frame_open_q, .mode3_q, .busy_q, .op_done_q,
        .op_refused_q, .read_ready_q, .write_ready_q, .standby_q, .active_q);

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Opens a frame with the clock parked at the requested idle level.
    task automatic open_frame(input logic m3);
        idle_high = m3;
        step(1);
        frame_req = 1'b1;
        step(4);
        check("frame_open_q", 1, frame_open_q);
        check("mode3_q", m3, mode3_q);
    endtask
    task automatic close_frame();
        frame_req = 1'b0;
        step(4);
        check("frame_open_q", 0, frame_open_q);
        check("so_oe_q", 0, so_oe_q);
    endtask
    // Starts an operation, repeats the request while busy, and times busy.
    task automatic run_op(input int k, input int exp_n);
        int n;
        op_kind = flash_power_pkg::op_kind_t'(k);
        op_start = 1'b1;
        step(2);
        op_start = 1'b0;
        check("op_refused_q", 1, op_refused_q);
        n = 1;
        while (busy_q === 1'b1 && n < 2000) begin
            n++;
            step(1);
        end
        check("busy length", exp_n, n);
        check("op_done_q", 1, op_done_q);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (write_ready_q !== 1'b1 && n < 1000) begin
            n++;
            step(1);
        end
        step(3);
    endtask
    // Select held low through reset opens nothing and requests are ignored.
    task automatic t_reset();
        out_request = 1'b1;
        step(8);
        check("busy_q in reset", 0, busy_q);
        rst = 1'b0;
        step(4);
        op_start = 1'b1;
        step(1);
        op_start = 1'b0;
        step(1);
        check("frame_open_q", 0, frame_open_q);
        check("busy_q", 0, busy_q);
        check("so_oe_q", 0, so_oe_q);
        frame_req = 1'b0;
        step(2);
    endtask
    // Array operation too early is refused; status write goes through.
    task automatic t_early();
        open_frame(1'b0);
        check("so_oe_q", 1, so_oe_q);
        op_kind = flash_power_pkg::OP_PAGE_WRITE;
        op_start = 1'b1;
        step(1);
        op_start = 1'b0;
        check("op_refused_q", 1, op_refused_q);
        check("busy_q", 0, busy_q);
        run_op(7, STATUS_N);
        close_frame();
    endtask
    task automatic t_ready();
        wait_ready();
        check("read_ready_q", 1, read_ready_q);
        check("standby_q", 1, standby_q);
        check("active_q", 0, active_q);
    endtask
    task automatic t_ops();
        for (int k = 0; k < 7; k++) begin
            open_frame(k[0]);
            run_op(k, DUR[k]);
            close_frame();
        end
    endtask
    // Reset again mid-run with select low until the delay ends.
    task automatic t_active();
        rst = 1'b1;
        frame_req = 1'b1;
        step(8);
        rst = 1'b0;
        wait_ready();
        check("active_q", 1, active_q);
        check("standby_q", 0, standby_q);
        frame_req = 1'b0;
        step(3);
    endtask

    initial begin
        t_reset();
        t_early();
        t_ready();
        t_ops();
        t_active();
        complete_run();
    end
    // Watchdog at several times the test length.
    initial begin
        #20000;
        num_errors++;
        complete_run();
    end
endmodule // flash_powerup_busy_tb_top
